// *** rtl/rstc_regs.svh ***
// register addresses, bit positions and reset values for the reset-cause block
// assumes an 8-bit cpu data path with 16-bit addresses
`ifndef RSTC_REGS_SVH
`define RSTC_REGS_SVH

`define ADDR_LOW_VOLTAGE_CONTROL 16'hff78
`define ADDR_RESET_CAUSE_FLAGS   16'hffac
`define RESET_VALUE_BYTE         8'h00

`define BIT_DETECTOR_ENABLE      3'h7
`define BIT_RESPONSE_MODE        3'h1
`define BIT_LOW_SUPPLY_FLAG      3'h0
`define BIT_WATCHDOG_CAUSE       3'h4
`define BIT_LOWVOLT_CAUSE        3'h0
`define BIT_WRITE_VALUE          3'h0

`define SYNC_WIDTH               3
`define SYNC_PIN_RESET           2'h0
`define SYNC_POWER_ON_LOW        2'h1
`define SYNC_LOW_SUPPLY          2'h2

`endif

// *** rtl/rstc_pkg.sv ***
// types shared by the reset-cause block
// assumes rstc_regs.svh for numeric constants
package rstc_pkg;
  typedef logic [15:0] addr_t;
  typedef logic [7:0]  data_t;
  typedef logic [2:0]  bit_idx_t;
endpackage : rstc_pkg

// *** rtl/sync_if.sv ***
// carrier between the block and its input synchroniser
// assumes both ends share core_clk_in
`timescale 1ns/100ps
interface sync_if #(parameter int WIDTH = 3);
  logic [WIDTH-1:0] raw;
  logic [WIDTH-1:0] synced;
  modport user (output raw, input synced);
  modport sync (input raw, output synced);
endinterface : sync_if

// *** rtl/input_sync.sv ***
// two-flop synchroniser bank for asynchronous inputs
// assumes inputs may change at any time relative to core_clk_in
`timescale 1ns/100ps
module input_sync #(
  parameter int WIDTH = 3
) (
  // clock and reset
  input  wire logic core_clk_in,
  input  wire logic arst_n_in,
  // raw and synchronised levels
  sync_if.sync      port
);
  logic [WIDTH-1:0] stage1;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
          stage1[i]      <= 1'b0;
          port.synced[i] <= 1'b0;
        end else begin
          stage1[i]      <= port.raw[i];
          port.synced[i] <= stage1[i];
        end
      end
    end
  endgenerate
endmodule : input_sync

// *** rtl/reset_cause_lvd.sv ***
// reset-cause recording and low-voltage supervisor control
// assumes comparator outputs and reset pin are asynchronous; watchdog pulse is on core_clk_in
`timescale 1ns/100ps
`include "rstc_regs.svh"
module reset_cause_lvd (
  // clock and reset
  input  wire logic             core_clk_in,
  input  wire logic             arst_n_in,
  // reset and supply sources
  input  wire logic             ext_reset_n_in,
  input  wire logic             power_on_low_in,
  input  wire logic             low_supply_in,
  input  wire logic             watchdog_overflow_in,
  // cpu register port
  input  wire rstc_pkg::addr_t  addr_in,
  input  wire logic             rd_in,
  input  wire logic             byte_wr_in,
  input  wire logic             bit_wr_in,
  input  wire rstc_pkg::bit_idx_t bit_sel_in,
  input  wire rstc_pkg::data_t  wdata_in,
  output rstc_pkg::data_t       rdata_out,
  // system outputs
  output logic                  internal_reset_out,
  output logic                  low_supply_interrupt_out
);
  import rstc_pkg::*;

  // control register state
  logic  detector_enable;
  logic  response_mode_select;
  logic  low_supply_flag;
  // reset-cause state
  logic  watchdog_cause_flag;
  logic  lowvolt_cause_flag;
  // synchronised source levels
  logic  pin_reset;
  logic  power_on_low;
  logic  low_supply;
  // decoded events
  logic  hard_clear;
  logic  lowvolt_reset_req;
  logic  ctrl_hit;
  logic  cause_hit;
  logic  cause_read;
  logic  ctrl_write_blocked;
  logic  ctrl_byte_write;
  logic  ctrl_bit_write;
  logic  bit_value;
  // read-back values
  data_t ctrl_value;
  data_t cause_value;
  data_t next_rdata;

  sync_if #(.WIDTH(`SYNC_WIDTH)) sync_bus ();

  // pin and comparator levels are async, two flops before any use
  assign sync_bus.raw[`SYNC_PIN_RESET]    = ~ext_reset_n_in;
  assign sync_bus.raw[`SYNC_POWER_ON_LOW] = power_on_low_in;
  assign sync_bus.raw[`SYNC_LOW_SUPPLY]   = low_supply_in;

  input_sync #(.WIDTH(`SYNC_WIDTH)) u_sync (
    .core_clk_in (core_clk_in),
    .arst_n_in   (arst_n_in),
    .port        (sync_bus.sync)
  );

  assign pin_reset    = sync_bus.synced[`SYNC_PIN_RESET];
  assign power_on_low = sync_bus.synced[`SYNC_POWER_ON_LOW];
  assign low_supply   = sync_bus.synced[`SYNC_LOW_SUPPLY];

  // pin and power-on resets clear both control bits and both cause flags
  assign hard_clear = pin_reset | power_on_low;
  // detector runs on the free clock, no stop-mode gating
  assign lowvolt_reset_req = detector_enable & response_mode_select & low_supply;

  // register decode
  assign ctrl_hit   = addr_in == `ADDR_LOW_VOLTAGE_CONTROL;
  assign cause_hit  = addr_in == `ADDR_RESET_CAUSE_FLAGS;
  assign cause_read = rd_in & cause_hit;
  // a write racing a reset source is dropped, the reset decides the value
  assign ctrl_write_blocked = hard_clear | watchdog_overflow_in | lowvolt_reset_req;
  assign ctrl_byte_write    = byte_wr_in & ctrl_hit & ~ctrl_write_blocked;
  assign ctrl_bit_write     = bit_wr_in & ctrl_hit & ~ctrl_write_blocked;
  // single-bit writes carry their value in the low data bit
  assign bit_value          = wdata_in[`BIT_WRITE_VALUE];

  // internal reset request, high from power-up
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      internal_reset_out <= 1'b1;
    end else begin
      internal_reset_out <= hard_clear | watchdog_overflow_in | lowvolt_reset_req;
    end
  end

  // detector enable, bit 7
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      detector_enable <= 1'b0;
    end else if (hard_clear || watchdog_overflow_in) begin
      detector_enable <= 1'b0;
    end else if (lowvolt_reset_req) begin
      detector_enable <= detector_enable;
    end else if (ctrl_byte_write) begin
      detector_enable <= wdata_in[`BIT_DETECTOR_ENABLE];
    end else if (ctrl_bit_write && bit_sel_in == `BIT_DETECTOR_ENABLE) begin
      detector_enable <= bit_value;
    end
  end

  // response mode select, bit 1
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      response_mode_select <= 1'b0;
    end else if (hard_clear || watchdog_overflow_in) begin
      response_mode_select <= 1'b0;
    end else if (lowvolt_reset_req) begin
      response_mode_select <= response_mode_select;
    end else if (ctrl_byte_write) begin
      response_mode_select <= wdata_in[`BIT_RESPONSE_MODE];
    end else if (ctrl_bit_write && bit_sel_in == `BIT_RESPONSE_MODE) begin
      response_mode_select <= bit_value;
    end
  end

  // status flag, read-only to software
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      low_supply_flag <= 1'b0;
    end else begin
      low_supply_flag <= detector_enable & low_supply;
    end
  end

  // non-maskable interrupt request, a level following the flag while response mode select is 0
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      low_supply_interrupt_out <= 1'b0;
    end else begin
      // no mask term: interrupt cannot be masked here
      low_supply_interrupt_out <= low_supply_flag & detector_enable
                                  & ~response_mode_select;
    end
  end

  // watchdog cause, a new cause wins over a read clear
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      watchdog_cause_flag <= 1'b0;
    end else if (hard_clear) begin
      watchdog_cause_flag <= 1'b0;
    end else if (watchdog_overflow_in) begin
      watchdog_cause_flag <= 1'b1;
    end else if (cause_read) begin
      watchdog_cause_flag <= 1'b0;
    end
  end

  // low-voltage cause, a new cause wins over a read clear
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      lowvolt_cause_flag <= 1'b0;
    end else if (hard_clear) begin
      lowvolt_cause_flag <= 1'b0;
    end else if (lowvolt_reset_req) begin
      lowvolt_cause_flag <= 1'b1;
    end else if (cause_read) begin
      lowvolt_cause_flag <= 1'b0;
    end
  end

  // control read-back, spare bits zero
  always_comb begin
    ctrl_value                       = `RESET_VALUE_BYTE;
    ctrl_value[`BIT_DETECTOR_ENABLE] = detector_enable;
    ctrl_value[`BIT_RESPONSE_MODE]   = response_mode_select;
    ctrl_value[`BIT_LOW_SUPPLY_FLAG] = low_supply_flag;
  end

  // cause read-back, spare bits zero
  always_comb begin
    cause_value                      = `RESET_VALUE_BYTE;
    cause_value[`BIT_WATCHDOG_CAUSE] = watchdog_cause_flag;
    cause_value[`BIT_LOWVOLT_CAUSE]  = lowvolt_cause_flag;
  end

  // read mux, unmapped addresses read zero
  always_comb begin
    next_rdata = `RESET_VALUE_BYTE;
    if (ctrl_hit) begin
      next_rdata = ctrl_value;
    end else if (cause_hit) begin
      next_rdata = cause_value;
    end
  end

  // read data holds until the next read
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rdata_out <= `RESET_VALUE_BYTE;
    end else if (rd_in) begin
      rdata_out <= next_rdata;
    end
  end
endmodule : reset_cause_lvd

// *** bench/reset_cause_lvd_properties.sv ***
// port-level assertions for the reset-cause block
// assumes a bind from the bench top file
`timescale 1ns/100ps
module reset_cause_lvd_properties import rstc_pkg::*; (
  input wire logic    core_clk_in, arst_n_in, ext_reset_n_in, power_on_low_in,
  input wire logic    low_supply_in, watchdog_overflow_in, rd_in, byte_wr_in, bit_wr_in,
  input wire addr_t   addr_in,
  input wire bit_idx_t bit_sel_in,
  input wire data_t   wdata_in, rdata_out,
  input wire logic    internal_reset_out, low_supply_interrupt_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!arst_n_in);
  sequence s_rd(a);
    rd_in && addr_in == a;
  endsequence
  property p_watchdog; watchdog_overflow_in |=> internal_reset_out; endproperty
  a_watchdog: assert property (p_watchdog) else $error("no reset after watchdog");
  property p_power_on; power_on_low_in [*4] |=> internal_reset_out; endproperty
  a_power_on: assert property (p_power_on) else $error("no power-on reset");
  property p_pin; !ext_reset_n_in [*4] |=> internal_reset_out; endproperty
  a_pin: assert property (p_pin) else $error("no pin reset");
  property p_quiet; !low_supply_in [*6] |-> !low_supply_interrupt_out; endproperty
  a_quiet: assert property (p_quiet) else $error("interrupt with good supply");
  property p_clr;
    s_rd(16'hffac) ##0 !watchdog_overflow_in ##1 s_rd(16'hffac) ##0 !internal_reset_out
      |=> rdata_out == 8'h00;
  endproperty
  a_clr: assert property (p_clr) else $error("cause not cleared by read");
  property p_cbits; s_rd(16'hffac) |=> (rdata_out & 8'hee) == 8'h00; endproperty
  a_cbits: assert property (p_cbits) else $error("cause spare bits set");
  property p_lbits; s_rd(16'hff78) |=> (rdata_out & 8'h7c) == 8'h00; endproperty
  a_lbits: assert property (p_lbits) else $error("control spare bits set");
  property p_unmap;
    rd_in && addr_in != 16'hff78 && addr_in != 16'hffac |=> rdata_out == 8'h00;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
endmodule : reset_cause_lvd_properties

// *** bench/supply_model.sv ***
// supply comparators with an analog delay off the clock
// assumes the bench sets the supply state
`timescale 1ns/100ps
module supply_model (
  input  wire logic supply_low_in,
  input  wire logic supply_dead_in,
  output wire logic low_supply_out,
  output wire logic power_on_low_out
);
  assign #37 low_supply_out = supply_low_in;
  assign #41 power_on_low_out = supply_dead_in;
endmodule : supply_model

// *** bench/reset_cause_lvd_tb.sv ***
// self-checking bench for the reset-cause block
// assumes rtl, checker and supply model compiled first
`timescale 1ns/100ps
module reset_cause_lvd_tb;
  import rstc_pkg::*;
  logic core_clk_in, arst_n_in, ext_reset_n_in, watchdog_overflow_in, rd_in, byte_wr_in;
  logic bit_wr_in, supply_low, supply_dead, internal_reset_out, low_supply_interrupt_out;
  wire logic power_on_low_in, low_supply_in;
  addr_t    addr_in;
  data_t    wdata_in, rdata_out;
  bit_idx_t bit_sel_in;
  int       num_errors = 0;
  int       n_compared = 0;
  localparam addr_t ctl_a = 16'hff78;
  localparam addr_t cause_a = 16'hffac;
  reset_cause_lvd DUT (.core_clk_in, .arst_n_in, .ext_reset_n_in, .power_on_low_in,
    .low_supply_in, .watchdog_overflow_in, .addr_in, .rd_in, .byte_wr_in, .bit_wr_in,
    .bit_sel_in, .wdata_in, .rdata_out, .internal_reset_out, .low_supply_interrupt_out);
  supply_model u_supply (.supply_low_in(supply_low), .supply_dead_in(supply_dead),
    .low_supply_out(low_supply_in), .power_on_low_out(power_on_low_in));
  initial begin
    core_clk_in = 0;
    forever #50 core_clk_in = ~core_clk_in;
  end
  task automatic end_sim;
    if (num_errors == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_sim
  task automatic chk(input string what, input data_t got, input data_t exp);
    n_compared++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", what, exp, got);
      num_errors++;
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_in);
    #1;
  endtask : tick
  // k: 0 read, 1 byte write, 2 bit write (index d[6:4], value d[0])
  task automatic acc(input int k, input addr_t a, input data_t d);
    {addr_in, wdata_in, bit_sel_in} = {a, d, d[6:4]};
    {bit_wr_in, byte_wr_in, rd_in} = {k == 2, k == 1, k == 0};
    tick(1);
    {bit_wr_in, byte_wr_in, rd_in} = 3'h0;
    tick(1);
  endtask : acc
  task automatic rd(input addr_t a, input data_t e);
    acc(0, a, 8'h00);
    chk("read data", rdata_out, e);
  endtask : rd
  task automatic sig(input string what, input logic s, input logic e);
    chk(what, {7'h0, s}, {7'h0, e});
  endtask : sig
  task automatic t_regs;
    rd(ctl_a, 8'h00);
    rd(16'h1234, 8'h00);
    acc(1, cause_a, 8'hff);
    rd(cause_a, 8'h00);
    acc(1, ctl_a, 8'hff);
    rd(ctl_a, 8'h82);
    acc(2, ctl_a, 8'h10);
    acc(2, ctl_a, 8'h70);
    rd(ctl_a, 8'h00);
  endtask : t_regs
  task automatic t_watchdog;
    acc(1, ctl_a, 8'h82);
    watchdog_overflow_in = 1;
    tick(1);
    watchdog_overflow_in = 0;
    sig("internal reset", internal_reset_out, 1);
    tick(3);
    rd(ctl_a, 8'h00);
    // two back-to-back cause reads: second sees the cleared value
    {addr_in, rd_in} = {cause_a, 1'b1};
    tick(1);
    chk("cause", rdata_out, 8'h10);
    tick(1);
    rd_in = 0;
    chk("cause", rdata_out, 8'h00);
    watchdog_overflow_in = 1;
    tick(1);
    {watchdog_overflow_in, ext_reset_n_in} = 2'b00;
    tick(5);
    ext_reset_n_in = 1;
    tick(5);
    rd(cause_a, 8'h00);
  endtask : t_watchdog
  task automatic t_lvd;
    acc(1, ctl_a, 8'h80);
    supply_low = 1;
    tick(6);
    sig("interrupt", low_supply_interrupt_out, 1);
    rd(ctl_a, 8'h81);
    acc(1, ctl_a, 8'h00);
    tick(2);
    sig("interrupt", low_supply_interrupt_out, 0);
    rd(ctl_a, 8'h00);
    acc(1, ctl_a, 8'h82);
    tick(6);
    sig("internal reset", internal_reset_out, 1);
    sig("interrupt", low_supply_interrupt_out, 0);
    rd(ctl_a, 8'h83);
    acc(1, ctl_a, 8'h00);
    rd(ctl_a, 8'h83);
    supply_low = 0;
    tick(6);
    rd(cause_a, 8'h01);
    rd(ctl_a, 8'h82);
    supply_dead = 1;
    tick(6);
    sig("internal reset", internal_reset_out, 1);
    supply_dead = 0;
    tick(6);
    rd(ctl_a, 8'h00);
  endtask : t_lvd
  initial begin
    {arst_n_in, ext_reset_n_in, watchdog_overflow_in, rd_in, byte_wr_in, bit_wr_in} = 6'h10;
    {supply_low, supply_dead, addr_in, wdata_in, bit_sel_in} = '0;
    tick(2);
    arst_n_in = 1;
    t_regs();
    t_watchdog();
    t_lvd();
    end_sim();
  end
  initial begin
    #100000;
    num_errors++;
    end_sim();
  end
endmodule : reset_cause_lvd_tb
bind reset_cause_lvd reset_cause_lvd_properties u_props (.core_clk_in, .arst_n_in,
  .ext_reset_n_in, .power_on_low_in, .low_supply_in, .watchdog_overflow_in, .rd_in,
  .byte_wr_in, .bit_wr_in, .addr_in, .bit_sel_in, .wdata_in, .rdata_out,
  .internal_reset_out, .low_supply_interrupt_out);
